// [hdl/uhfp_regs.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "uhfp_params.svh"

module uhfp_regs #(
  parameter int FRAME_W = `UHFP_FRAME_W
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire uhfp_pkg::uhfp_bus_req_t bus_in,
  output logic [31:0] rdata_out,
  input wire logic frame_end_in,
  input wire logic power_switch_capability_in,
  input wire logic indicator_support_in,
  input wire uhfp_pkg::uhfp_line_t line_in,
  output logic [FRAME_W-1:0] frame_counter_out,
  output logic configure_done_flag_out,
  output uhfp_pkg::uhfp_port_ctrl_t port_ctrl_out,
  output logic port_test_active_out
);

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  // Three stages; a change counts once stages two and three agree
  uhfp_pkg::uhfp_line_t line_s1;
  uhfp_pkg::uhfp_line_t line_s2;
  uhfp_pkg::uhfp_line_t line_s3;
  uhfp_pkg::uhfp_line_t line_q;
  wire uhfp_pkg::uhfp_line_t next_line_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      line_s1 <= '0;
      line_s2 <= '0;
      line_s3 <= '0;
      line_q <= '0;
    end else begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      line_q <= next_line_q;
    end
  end

  // Per-bit filter: follow only when stages agree
  assign next_line_q = (line_s2 & line_s3) | (line_q & (line_s2 | line_s3));

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_frame = bus_in.wr && hit(bus_in.addr,
    `UHFP_FRAME_COUNTER_OFS);
  wire logic wr_cfg = bus_in.wr && hit(bus_in.addr,
    `UHFP_CONFIGURE_DONE_OFS);
  wire logic wr_port = bus_in.wr && hit(bus_in.addr, `UHFP_PORT1_SC_OFS);
  wire logic [31:0] wd = bus_in.wdata;

  // ****************************************
  // Frame counter and configure flag
  // ****************************************
  logic [FRAME_W-1:0] frame_counter;
  logic configure_done_flag;
  logic [FRAME_W-1:0] next_frame_counter;
  wire logic cfg_rise = wr_cfg && wd[0] && !configure_done_flag;
  // Owner must follow the flag in the same cycle it changes
  wire logic next_cfg = wr_cfg ? wd[0] : configure_done_flag;
  wire logic [31:0] port_reset_word = `UHFP_PORT_RESET_VAL;

  // Software write wins over a coincident frame end
  assign next_frame_counter = wr_frame ? wd[FRAME_W-1:0] :
    frame_end_in ? frame_counter + 1'b1 : frame_counter;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      frame_counter <= `UHFP_FRAME_RESET_VAL;
      configure_done_flag <= `UHFP_CFG_RESET_VAL;
    end else begin
      frame_counter <= next_frame_counter;
      if (wr_cfg) begin
        configure_done_flag <= wd[0];
      end
    end
  end

  // ****************************************
  // Port status and control
  // ****************************************
  logic [3:0] test_select;
  logic [1:0] led_control;
  logic handoff_owner;
  logic port_power;
  logic suspend;
  logic enable;
  logic connect_change;
  logic connect_prev;
  logic next_owner;
  logic next_connect_change;

  // Without switch capability the port is always powered
  wire logic power_eff = port_power || !power_switch_capability_in;
  // Writes to state fields only land while powered
  wire logic state_wr = wr_port && power_eff;
  wire logic connect_now = line_q.connect && power_eff;
  wire logic connect_edge = connect_now != connect_prev;

  // Rising configure flag wins; clear flag forces owner high
  assign next_owner = cfg_rise ? 1'b0 :
    !next_cfg ? 1'b1 :
    state_wr ? wd[`UHFP_PO_BIT] : handoff_owner;

  // A change in the same cycle as the clear still sets the flag
  assign next_connect_change = connect_edge ? 1'b1 :
    (state_wr && wd[`UHFP_CSC_BIT]) ? 1'b0 : connect_change;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      test_select <= '0;
      led_control <= '0;
      handoff_owner <= port_reset_word[`UHFP_PO_BIT];
      port_power <= 1'b0;
      suspend <= 1'b0;
      enable <= 1'b0;
      connect_change <= 1'b0;
      connect_prev <= 1'b0;
    end else begin
      handoff_owner <= next_owner;
      connect_change <= next_connect_change;
      connect_prev <= connect_now;
      if (wr_port && power_switch_capability_in) begin
        port_power <= wd[`UHFP_PP_BIT];
      end
      if (state_wr) begin
        test_select <= wd[`UHFP_PTC_LSB +: 4];
        suspend <= wd[`UHFP_SUSP_BIT];
        enable <= wd[`UHFP_PED_BIT];
        if (indicator_support_in) begin
          led_control <= wd[`UHFP_PIC_LSB +: 2];
        end
      end
      // Losing the device or power disables the port
      if (!connect_now) begin
        enable <= 1'b0;
        suspend <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  logic [31:0] port_word;
  logic [31:0] next_rdata;

  always_comb begin
    port_word = '0;
    port_word[`UHFP_PTC_LSB +: 4] = test_select;
    port_word[`UHFP_PIC_LSB +: 2] = led_control;
    port_word[`UHFP_PO_BIT] = handoff_owner;
    port_word[`UHFP_PP_BIT] = port_power;
    port_word[`UHFP_LS_LSB +: 2] = {line_q.dp, line_q.dm};
    if (power_eff) begin
      port_word[`UHFP_PR_BIT] = line_q.reset_active;
      port_word[`UHFP_SUSP_BIT] = suspend;
      port_word[`UHFP_FPR_BIT] = line_q.resume_seen;
      port_word[`UHFP_PED_BIT] = enable;
      port_word[`UHFP_CSC_BIT] = connect_change;
      port_word[`UHFP_CCS_BIT] = connect_now;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (hit(bus_in.addr, `UHFP_FRAME_COUNTER_OFS)) begin
      next_rdata[FRAME_W-1:0] = frame_counter;
    end else if (hit(bus_in.addr, `UHFP_CONFIGURE_DONE_OFS)) begin
      next_rdata[0] = configure_done_flag;
    end else if (hit(bus_in.addr, `UHFP_PORT1_SC_OFS)) begin
      next_rdata = port_word;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign frame_counter_out = frame_counter;
  assign configure_done_flag_out = configure_done_flag;
  assign port_test_active_out = |test_select;
  assign port_ctrl_out = '{test_select: test_select,
    led_control: led_control, handoff_owner: handoff_owner,
    power: port_power, reset_flag: port_word[`UHFP_PR_BIT],
    suspend: port_word[`UHFP_SUSP_BIT],
    force_resume: port_word[`UHFP_FPR_BIT],
    enable: port_word[`UHFP_PED_BIT]};

endmodule

// [hdl/uhfp_params.svh]
`ifndef UHFP_PARAMS_SVH
`define UHFP_PARAMS_SVH

// Register offsets (byte addresses)
`define UHFP_FRAME_COUNTER_OFS 8'h2c
`define UHFP_CONFIGURE_DONE_OFS 8'h60
`define UHFP_PORT1_SC_OFS 8'h64

// Frame counter field
`define UHFP_FRAME_W 14

// Port status and control field positions
`define UHFP_PTC_LSB 16
`define UHFP_PIC_LSB 14
`define UHFP_PO_BIT 13
`define UHFP_PP_BIT 12
`define UHFP_LS_LSB 10
`define UHFP_PR_BIT 8
`define UHFP_SUSP_BIT 7
`define UHFP_FPR_BIT 6
`define UHFP_PED_BIT 2
`define UHFP_CSC_BIT 1
`define UHFP_CCS_BIT 0

// Reset values
`define UHFP_PORT_RESET_VAL 32'h0000_2000
`define UHFP_CFG_RESET_VAL 1'b0
`define UHFP_FRAME_RESET_VAL 14'h0000

`endif

// [hdl/uhfp_pkg.sv]
package uhfp_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhfp_bus_req_t;

  typedef struct packed {
    logic [3:0] test_select;
    logic [1:0] led_control;
    logic handoff_owner;
    logic power;
    logic reset_flag;
    logic suspend;
    logic force_resume;
    logic enable;
  } uhfp_port_ctrl_t;

  typedef struct packed {
    logic dp;
    logic dm;
    logic connect;
    logic reset_active;
    logic resume_seen;
  } uhfp_line_t;

endpackage

// [testbench/uhfp_regs_properties.sv]
`timescale 1ns/10ps
// ****
// Frame counter, flag and port checks
// ****
module uhfp_regs_properties #(
  parameter int FRAME_W = 14
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire uhfp_pkg::uhfp_bus_req_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire logic frame_end_in,
  input wire logic power_switch_capability_in,
  input wire logic [FRAME_W-1:0] frame_counter_out,
  input wire logic configure_done_flag_out,
  input wire uhfp_pkg::uhfp_port_ctrl_t port_ctrl_out,
  input wire logic port_test_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire fr_wr = bus_in.wr && bus_in.addr == 8'h2c;
  sequence s_tick;
    frame_end_in && !fr_wr;
  endsequence
  sequence s_read(a);
    bus_in.rd && bus_in.addr == a;
  endsequence
  a_frame_step: assert property (s_tick |=>
    frame_counter_out == $past(frame_counter_out) + 1'b1) else $error("step");
  a_frame_hold: assert property (!frame_end_in && !fr_wr |=>
    $stable(frame_counter_out)) else $error("frame moved");
  a_frame_read: assert property (s_read(8'h2c) |=>
    rdata_out == 32'($past(frame_counter_out))) else $error("frame read");
  a_flag_read: assert property (s_read(8'h60) |=>
    rdata_out == 32'($past(configure_done_flag_out))) else $error("flag");
  a_owner_high: assert property (!configure_done_flag_out |->
    port_ctrl_out.handoff_owner) else $error("owner low");
  a_owner_clear: assert property ($rose(configure_done_flag_out) |->
    !port_ctrl_out.handoff_owner) else $error("owner kept");
  a_unpowered_zero: assert property (power_switch_capability_in &&
    !port_ctrl_out.power |-> port_ctrl_out[3:0] == 4'h0) else $error("gate");
  a_test_flag: assert property (port_test_active_out ==
    (port_ctrl_out.test_select != 4'h0)) else $error("test flag");
  a_port_read: assert property (s_read(8'h64) |=>
    rdata_out[19:12] == $past(port_ctrl_out[11:4])) else $error("port");
endmodule

bind uhfp_regs uhfp_regs_properties #(.FRAME_W(FRAME_W)) uhfp_regs_prop_i (
  .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .frame_end_in(frame_end_in),
  .power_switch_capability_in(power_switch_capability_in),
  .frame_counter_out(frame_counter_out),
  .configure_done_flag_out(configure_done_flag_out),
  .port_ctrl_out(port_ctrl_out), .port_test_active_out(port_test_active_out));

// [testbench/uhfp_peripheral_model.sv]
`timescale 1ns/10ps
// ****
// Attached peripheral
// ****
module uhfp_peripheral_model (
  input wire logic attach_in,
  input wire logic [1:0] mode_in,
  output uhfp_pkg::uhfp_line_t line_out
);
  // Idle J when attached; host pull-downs hold both lines low when gone
  assign line_out.dp = attach_in;
  assign line_out.dm = 1'b0;
  assign line_out.connect = attach_in;
  assign line_out.reset_active = attach_in && mode_in == 2'h1;
  assign line_out.resume_seen = attach_in && mode_in == 2'h2;
endmodule

// [testbench/usb_host_frame_and_port_regs_tb_top.sv]
`timescale 1ns/10ps
// ****
// Bench
// ****
module usb_host_frame_and_port_regs_tb_top;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  uhfp_pkg::uhfp_bus_req_t bus = '0;
  logic frame_end = 1'b0;
  logic ind_sup = 1'b0;
  logic attach = 1'b0;
  logic [1:0] mode = 2'h0;
  uhfp_pkg::uhfp_line_t line;
  logic [31:0] rdata;
  logic [13:0] fc;
  logic test_act;
  logic [13:0] v;
  int n;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 clk_in = ~clk_in;
  uhfp_peripheral_model uhfp_peripheral_model_i (.attach_in(attach),
    .mode_in(mode), .line_out(line));
  uhfp_regs uhfp_regs_i (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus),
    .rdata_out(rdata), .frame_end_in(frame_end),
    .power_switch_capability_in(1'b1), .indicator_support_in(ind_sup),
    .line_in(line), .frame_counter_out(fc), .configure_done_flag_out(),
    .port_ctrl_out(), .port_test_active_out(test_act));
  task automatic end_of_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_in);
    bus <= '{a, d, w, !w};
    @(posedge clk_in);
    bus <= '{a, d, 1'b0, 1'b0};
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    op(a, 32'h0, 1'b0);
    chk(rdata, e);
  endtask
  // Powered word with owner released
  function automatic logic [31:0] pw(input logic [3:0] t,
    input logic [1:0] ls, input logic [8:0] lo);
    pw = {12'h0, t, 4'h1, ls, 1'b0, lo};
  endfunction
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    end_of_test;
  end
  initial begin
    void'($urandom(59009));
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h64, 32'h2000);
    op(8'h64, 32'h0000_00c4, 1'b1);
    rd(8'h64, 32'h2000);
    op(8'h60, 32'h1, 1'b1);
    rd(8'h60, 32'h1);
    rd(8'h64, 32'h0);
    op(8'h60, 32'h0, 1'b1);
    rd(8'h64, 32'h2000);
    op(8'h60, 32'h1, 1'b1);
    rd(8'h64, 32'h0);
    op(8'h64, 32'h1000, 1'b1);
    // Short settle only: the block keeps no power-ramp count
    repeat (8) @(posedge clk_in);
    rd(8'h64, pw(4'h0, 2'h0, 9'h0));
    for (int i = 0; i < 16; i++) begin
      op(8'h64, pw(4'(i), 2'h0, 9'h0), 1'b1);
      rd(8'h64, pw(4'(i), 2'h0, 9'h0));
      chk(32'(test_act), 32'(i != 0));
    end
    op(8'h64, 32'hd000, 1'b1);
    rd(8'h64, 32'h1000);
    ind_sup <= 1'b1;
    op(8'h64, 32'hd000, 1'b1);
    rd(8'h64, 32'hd000);
    op(8'h64, 32'h1000, 1'b1);
    attach <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(8'h64, pw(4'h0, 2'h2, 9'h3));
    op(8'h64, 32'h1000, 1'b1);
    rd(8'h64, pw(4'h0, 2'h2, 9'h3));
    op(8'h64, 32'h1002, 1'b1);
    rd(8'h64, pw(4'h0, 2'h2, 9'h1));
    mode <= 2'h1;
    repeat (8) @(posedge clk_in);
    rd(8'h64, pw(4'h0, 2'h2, 9'h101));
    mode <= 2'h2;
    repeat (8) @(posedge clk_in);
    rd(8'h64, pw(4'h0, 2'h2, 9'h041));
    mode <= 2'h0;
    op(8'h64, 32'h0, 1'b1);
    rd(8'h64, 32'h0800);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 14'h3fff : 14'($urandom);
      n = $urandom_range(20, 1);
      op(8'h2c, 32'(v), 1'b1);
      repeat (n) begin
        @(posedge clk_in);
        frame_end <= 1'b1;
      end
      @(posedge clk_in);
      frame_end <= 1'b0;
      v = v + 14'(n);
      rd(8'h2c, 32'(v));
      chk(32'(fc), 32'(v));
    end
    attach <= 1'b0;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(8'h64, 32'h2000);
    rd(8'h60, 32'h0);
    end_of_test;
  end
endmodule
